// ===== rtl/adc_sweep_pkg.sv
// Constants, register map and types shared by the sweep sequencer and its pin engine.
// Functional notes
// - Single sweep converts pins in ascending order.
// - Setting start bit begins sweep at pin zero.
// - Conversion takes 49/59 cycles, then stores result.
// - Comparator pin finishes after 14 cycles, stores bit.
// - Each pin result stored when that pin ends.
// - Single sweep end: raise request, clear start, halt.
// - Select 10 sweeps pins 0-5 in six slots, storing pins 0-4.
// - Repeat sweep: no request, start stays set.
// - Repeat sweep restarts at pin zero until stopped.
// - Comparator result registers read only while halted.
// - Comparator reference is result byte plus 10.
// - Eight-bit mode delivers upper eight approximation bits.
package adc_sweep_pkg;

  localparam int unsigned NUM_PINS  = 8;
  localparam int unsigned SAR_BITS  = 10;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned LEN_W     = 6;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL0    = 8'h00;
  localparam logic [7:0] ADDR_CTRL1    = 8'h01;
  localparam logic [7:0] ADDR_CMP_SEL  = 8'h02;
  localparam logic [7:0] ADDR_CMP_RES  = 8'h03;
  localparam logic [7:0] ADDR_DA_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h05;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h06;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h07;
  localparam logic [7:0] ADDR_RESULT0  = 8'h10;

  // Field positions.
  localparam int unsigned CTRL0_MODE_BIT  = 0;
  localparam int unsigned CTRL0_RES8_BIT  = 1;
  localparam int unsigned CTRL0_VREF_BIT  = 2;
  localparam int unsigned CTRL0_START_BIT = 6;
  localparam int unsigned IRQ_SWEEP_BIT   = 0;

  // Reset values.
  localparam logic [7:0] CTRL0_RESET   = 8'h00;
  localparam logic [1:0] CTRL1_RESET   = 2'h0;
  localparam logic [7:0] CMP_SEL_RESET = 8'h00;
  localparam logic [7:0] CMP_RES_RESET = 8'h00;
  localparam logic [1:0] DA_RESET      = 2'h0;
  localparam logic [9:0] RESULT_RESET  = 10'h000;

  // Sweep pin select encodings and their slot and stored-pin counts.
  localparam logic [1:0] SEL_PINS_2 = 2'h0;
  localparam logic [1:0] SEL_PINS_4 = 2'h1;
  localparam logic [1:0] SEL_PINS_5 = 2'h2;
  localparam logic [1:0] SEL_PINS_8 = 2'h3;
  localparam logic [3:0] SLOTS_2    = 4'h2;
  localparam logic [3:0] SLOTS_4    = 4'h4;
  localparam logic [3:0] SLOTS_5    = 4'h6;
  localparam logic [3:0] STORED_5   = 4'h5;
  localparam logic [3:0] SLOTS_8    = 4'h8;

  // Per-pin operation lengths in converter clock cycles.
  localparam logic [5:0] CONV8_CYCLES  = 6'h31;
  localparam logic [5:0] CONV10_CYCLES = 6'h3B;
  localparam logic [5:0] CMP_CYCLES    = 6'h0E;
  // The approximation window: first trial this many cycles before the end.
  localparam logic [5:0] SAR_LEAD      = 6'h0C;
  localparam logic [9:0] SAR_FIRST     = 10'h200;
  localparam logic [1:0] CMP_LOW_BITS  = 2'h2;

  // Reference settling time software must respect after reconnecting.
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned VREF_SETTLE_NS     = 1000;
  localparam int unsigned VREF_SETTLE_CYCLES =
    (VREF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {
    MODE_SINGLE_SWEEP,
    MODE_REPEAT_SWEEP0
  } sweep_mode_t;

endpackage

// ===== rtl/adc_pin_engine.sv
// One analog pin operation: successive approximation or single comparison.
`timescale 1ns/1ps
module adc_pin_engine (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  wire logic       i_cmp_mode,
  input  wire logic       i_res8,
  input  wire logic [7:0] i_ref,
  input  wire logic       i_cmp_hi,
  output logic            o_done,
  output logic [9:0]      o_result,
  output logic            o_cmp_bit,
  output logic [9:0]      o_dac
);

  logic [5:0] len_q;
  logic [5:0] cnt_q;
  logic       busy_q;
  logic       cmp_q;
  logic [7:0] ref_q;
  logic [3:0] bit_q;
  logic       trial_q;
  logic       last;

  assign last = busy_q && (cnt_q == len_q - 6'h01);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= 6'h00;
      len_q  <= adc_sweep_pkg::CONV10_CYCLES;
      cmp_q  <= 1'b0;
      ref_q  <= 8'h00;
    end else if (i_abort) begin
      busy_q <= 1'b0;
    end else if (i_start) begin
      busy_q <= 1'b1;
      cnt_q  <= 6'h00;
      cmp_q  <= i_cmp_mode;
      ref_q  <= i_ref;
      if (i_cmp_mode) begin
        len_q <= adc_sweep_pkg::CMP_CYCLES;
      end else if (i_res8) begin
        len_q <= adc_sweep_pkg::CONV8_CYCLES;
      end else begin
        len_q <= adc_sweep_pkg::CONV10_CYCLES;
      end
    end else if (busy_q) begin
      cnt_q <= cnt_q + 6'h01;
      if (last) begin
        busy_q <= 1'b0;
      end
    end
  end

  // The code is resolved MSB first; the last trial settles one cycle before the end.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dac   <= 10'h000;
      bit_q   <= 4'h0;
      trial_q <= 1'b0;
    end else if (i_start || i_abort) begin
      trial_q <= 1'b0;
    end else if (busy_q && cmp_q) begin
      if (cnt_q == len_q - 6'h02) begin
        o_dac <= {ref_q, adc_sweep_pkg::CMP_LOW_BITS};
      end
    end else if (busy_q) begin
      if (cnt_q == len_q - adc_sweep_pkg::SAR_LEAD) begin
        o_dac   <= adc_sweep_pkg::SAR_FIRST;
        bit_q   <= 4'h9;
        trial_q <= 1'b1;
      end else if (trial_q) begin
        o_dac[bit_q] <= i_cmp_hi;
        if (bit_q != 4'h0) begin
          o_dac[bit_q - 4'h1] <= 1'b1;
          bit_q               <= bit_q - 4'h1;
        end else begin
          trial_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_done    <= 1'b0;
      o_result  <= 10'h000;
      o_cmp_bit <= 1'b0;
    end else begin
      o_done <= last && !i_abort && !i_start;
      if (last && !cmp_q) begin
        o_result <= o_dac;
      end
      if (last && cmp_q) begin
        o_cmp_bit <= i_cmp_hi;
      end
    end
  end

endmodule // adc_pin_engine

// ===== rtl/adc_sweep_sequencer.sv
// Sweep sequencer for the successive-approximation converter with its register file.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ps
module adc_sweep_sequencer #(
  parameter int unsigned PINS = adc_sweep_pkg::NUM_PINS
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_cmp_hi,
  output logic      [2:0]  o_pin_sel,
  output logic      [9:0]  o_dac_code,
  output logic             o_busy,
  output logic             o_vref_connect,
  output logic      [1:0]  o_da_oe,
  output logic             o_irq
);

  if (PINS != adc_sweep_pkg::NUM_PINS) begin : g_bad_pins
    $error("adc_sweep_sequencer: pin count must be 8");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT
  } sweep_state_t;

  sweep_state_t state_q;

  logic [7:0] ctrl0_q;
  logic [1:0] ctrl1_q;
  logic [7:0] cmp_sel_q;
  logic [7:0] cmp_res_q;
  logic [1:0] da_oe_q;
  logic       start_q;
  logic [0:0] irq_stat_q;
  logic [0:0] irq_stat_d;
  logic [0:0] irq_en_q;
  logic [0:0] irq_clr;
  logic [2:0] pin_q;
  logic [9:0] result_q [adc_sweep_pkg::NUM_PINS];

  logic       wr_ctrl0;
  logic       wr_result;
  logic [3:0] slots;
  logic [3:0] stored;
  logic       last_slot;
  logic       abort;
  logic       eng_done;
  logic [9:0] eng_result;
  logic       eng_cmp_bit;
  logic [9:0] eng_dac;
  logic       pin_end;
  logic       store_en;
  logic       sweep_end;
  logic       single_end;
  logic       repeat_mode;
  logic       res8;
  logic [9:0] store_value;
  logic [15:0] rdata_d;

  assign wr_ctrl0    = i_wr && (i_addr == adc_sweep_pkg::ADDR_CTRL0);
  assign wr_result   = i_wr && (i_addr[7:3] == adc_sweep_pkg::ADDR_RESULT0[7:3]);
  assign repeat_mode = ctrl0_q[adc_sweep_pkg::CTRL0_MODE_BIT];
  assign res8        = ctrl0_q[adc_sweep_pkg::CTRL0_RES8_BIT];

  // Undescribed group sizes are fixed per encoding; select 10 adds a sixth slot that converts pin 5 but stores nothing.
  always_comb begin
    slots  = adc_sweep_pkg::SLOTS_8;
    stored = adc_sweep_pkg::SLOTS_8;
    case (ctrl1_q)
      adc_sweep_pkg::SEL_PINS_2: begin
        slots  = adc_sweep_pkg::SLOTS_2;
        stored = adc_sweep_pkg::SLOTS_2;
      end
      adc_sweep_pkg::SEL_PINS_4: begin
        slots  = adc_sweep_pkg::SLOTS_4;
        stored = adc_sweep_pkg::SLOTS_4;
      end
      adc_sweep_pkg::SEL_PINS_5: begin
        slots  = adc_sweep_pkg::SLOTS_5;
        stored = adc_sweep_pkg::STORED_5;
      end
      default: begin
        slots  = adc_sweep_pkg::SLOTS_8;
        stored = adc_sweep_pkg::SLOTS_8;
      end
    endcase
  end

  assign last_slot  = ({1'b0, pin_q} == slots - 4'h1);
  // Clearing the start bit mid-sweep abandons the pin in flight without storing it.
  assign abort      = (state_q != ST_IDLE) && !start_q;
  assign pin_end    = (state_q == ST_WAIT) && eng_done && !abort;
  assign store_en   = pin_end && ({1'b0, pin_q} < stored);
  assign sweep_end  = pin_end && last_slot;
  assign single_end = sweep_end && !repeat_mode;

  // Eight-bit results sit in the low bits, taken from the top of the code.
  assign store_value = res8 ? {2'h0, eng_result[9:2]} : eng_result;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl0_q   <= adc_sweep_pkg::CTRL0_RESET;
      ctrl1_q   <= adc_sweep_pkg::CTRL1_RESET;
      cmp_sel_q <= adc_sweep_pkg::CMP_SEL_RESET;
      da_oe_q   <= adc_sweep_pkg::DA_RESET;
      irq_en_q  <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        adc_sweep_pkg::ADDR_CTRL0:   ctrl0_q   <= i_wdata[7:0];
        adc_sweep_pkg::ADDR_CTRL1:   ctrl1_q   <= i_wdata[1:0];
        adc_sweep_pkg::ADDR_CMP_SEL: cmp_sel_q <= i_wdata[7:0];
        adc_sweep_pkg::ADDR_DA_CTRL: da_oe_q   <= i_wdata[1:0];
        adc_sweep_pkg::ADDR_IRQ_EN:  irq_en_q  <= i_wdata[0:0];
        default:                     irq_en_q  <= irq_en_q;
      endcase
    end
  end

  // A software write of the start bit in the same cycle as the sweep end wins.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= 1'b0;
    end else if (wr_ctrl0) begin
      start_q <= i_wdata[adc_sweep_pkg::CTRL0_START_BIT];
    end else if (single_end) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
      pin_q   <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            pin_q   <= 3'h0;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          state_q <= abort ? ST_IDLE : ST_WAIT;
        end
        ST_WAIT: begin
          if (abort) begin
            state_q <= ST_IDLE;
          end else if (sweep_end && repeat_mode) begin
            pin_q   <= 3'h0;
            state_q <= ST_START;
          end else if (sweep_end) begin
            state_q <= ST_IDLE;
          end else if (eng_done) begin
            pin_q   <= pin_q + 3'h1;
            state_q <= ST_START;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  adc_pin_engine u_engine (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_start    ((state_q == ST_START) && !abort),
    .i_abort    (abort),
    .i_cmp_mode (cmp_sel_q[pin_q]),
    .i_res8     (res8),
    .i_ref      (result_q[pin_q][7:0]),
    .i_cmp_hi   (i_cmp_hi),
    .o_done     (eng_done),
    .o_result   (eng_result),
    .o_cmp_bit  (eng_cmp_bit),
    .o_dac      (eng_dac)
  );

  // A pin ending in the cycle of a software write keeps the hardware value.
  for (genvar i = 0; i < adc_sweep_pkg::NUM_PINS; i++) begin : g_pin
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        result_q[i] <= adc_sweep_pkg::RESULT_RESET;
      end else if (store_en && !cmp_sel_q[i] && (pin_q == 3'(i))) begin
        result_q[i] <= store_value;
      end else if (wr_result && (i_addr[2:0] == 3'(i))) begin
        result_q[i] <= i_wdata[9:0];
      end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cmp_res_q[i] <= adc_sweep_pkg::CMP_RES_RESET[i];
      end else if (store_en && cmp_sel_q[i] && (pin_q == 3'(i))) begin
        cmp_res_q[i] <= eng_cmp_bit;
      end else if (i_wr && (i_addr == adc_sweep_pkg::ADDR_CMP_RES)) begin
        cmp_res_q[i] <= i_wdata[i];
      end
    end
  end

  // Only single sweep raises the request; a set in the clearing cycle survives.
  assign irq_clr    = (i_wr && (i_addr == adc_sweep_pkg::ADDR_IRQ_CLR)) ? i_wdata[0:0] : 1'b0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | {single_end};

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_q <= 1'b0;
      o_irq      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      o_irq      <= |(irq_stat_d & irq_en_q);
    end
  end

  // Comparator-mode result registers change during a sweep; read them only when halted.
  always_comb begin
    rdata_d = 16'h0000;
    case (i_addr)
      adc_sweep_pkg::ADDR_CTRL0:    rdata_d = {8'h00, ctrl0_q[7], start_q, ctrl0_q[5:0]};
      adc_sweep_pkg::ADDR_CTRL1:    rdata_d = {14'h0000, ctrl1_q};
      adc_sweep_pkg::ADDR_CMP_SEL:  rdata_d = {8'h00, cmp_sel_q};
      adc_sweep_pkg::ADDR_CMP_RES:  rdata_d = {8'h00, cmp_res_q};
      adc_sweep_pkg::ADDR_DA_CTRL:  rdata_d = {14'h0000, da_oe_q};
      adc_sweep_pkg::ADDR_IRQ_STAT: rdata_d = {15'h0000, irq_stat_q};
      adc_sweep_pkg::ADDR_IRQ_EN:   rdata_d = {15'h0000, irq_en_q};
      default: begin
        if (i_addr[7:3] == adc_sweep_pkg::ADDR_RESULT0[7:3]) begin
          rdata_d = {6'h00, result_q[i_addr[2:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rdata_d : 16'h0000;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_sel      <= 3'h0;
      o_dac_code     <= 10'h000;
      o_busy         <= 1'b0;
      o_vref_connect <= 1'b0;
      o_da_oe        <= adc_sweep_pkg::DA_RESET;
    end else begin
      o_pin_sel      <= pin_q;
      o_dac_code     <= eng_dac;
      o_busy         <= (state_q != ST_IDLE);
      o_vref_connect <= ctrl0_q[adc_sweep_pkg::CTRL0_VREF_BIT];
      o_da_oe        <= da_oe_q;
    end
  end

endmodule // adc_sweep_sequencer

// ===== verification/adc_sweep_sequencer_chk.sv
// Port-level assertions for the sweep sequencer.
`timescale 1ns/1ps
module adc_sweep_sequencer_chk (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic [2:0]  o_pin_sel,
  input wire logic        o_busy,
  input wire logic        o_vref_connect,
  input wire logic [1:0]  o_da_oe,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic mode_q;
  logic wr_c0;
  assign wr_c0 = i_wr && i_addr == adc_sweep_pkg::ADDR_CTRL0;
  // Software only changes the mode while halted, so a shadow copy is exact.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= 1'b0;
    end else if (wr_c0) begin
      mode_q <= i_wdata[0];
    end
  end
  AST_RD_IDLE:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
  AST_START_BUSY:
    assert property (wr_c0 && i_wdata[6] && !o_busy |-> ##[1:3] o_busy)
      else $error("start did not begin a sweep");
  AST_STOP:
    assert property (wr_c0 && !i_wdata[6] |-> ##[1:3] !o_busy) else $error("sweep not stopped");
  AST_NO_IRQ_REPEAT:
    assert property ($rose(o_irq) |-> !(mode_q && $past(o_busy)))
      else $error("request raised in repeat sweep");
  AST_PIN_ASC:
    assert property (o_busy && $past(o_busy) && !$stable(o_pin_sel)
      |-> o_pin_sel == $past(o_pin_sel) + 3'h1 || o_pin_sel == 3'h0)
      else $error("pin order broken");
  AST_IRQ_CLR:
    assert property (i_wr && i_addr == adc_sweep_pkg::ADDR_IRQ_CLR && i_wdata[0] && !o_busy
      |-> ##2 !o_irq) else $error("clear did not drop request");
  AST_IRQ_MASK:
    assert property (i_wr && i_addr == adc_sweep_pkg::ADDR_IRQ_EN && !i_wdata[0] |-> ##2 !o_irq)
      else $error("masked request visible");
  AST_DA_OE:
    assert property (i_wr && i_addr == adc_sweep_pkg::ADDR_DA_CTRL
      |-> ##2 o_da_oe == $past(i_wdata[1:0], 2)) else $error("output enable mismatch");
  AST_VREF:
    assert property (wr_c0 |-> ##2 o_vref_connect == $past(i_wdata[2], 2))
      else $error("reference connect mismatch");
endmodule // adc_sweep_sequencer_chk

bind adc_sweep_sequencer adc_sweep_sequencer_chk u_chk (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_sel(o_pin_sel), .o_busy(o_busy),
  .o_vref_connect(o_vref_connect), .o_da_oe(o_da_oe), .o_irq(o_irq)
);

// ===== verification/adc_analog_model.sv
// Analog inputs and multiplexer seen by the converter comparator.
`timescale 1ns/1ps
module adc_analog_model (
  input  wire logic [7:0] i_level,
  input  wire logic [2:0] i_pin_sel,
  output logic            o_cmp_hi
);
  // Each pin sits at a rail, so the answer never depends on the ladder code lag.
  assign o_cmp_hi = i_level[i_pin_sel];
endmodule // adc_analog_model

// ===== verification/test_adc_sweep_sequencer.sv
// Self-checking testbench for the sweep sequencer.
`timescale 1ns/1ps
module test_adc_sweep_sequencer;
  logic        i_core_clk = 1'b0;
  logic        i_arst_n;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic        cmp_hi;
  logic [2:0]  o_pin_sel;
  logic        o_busy;
  logic        o_vref_connect;
  logic [1:0]  o_da_oe;
  logic [9:0]  dac;
  logic        o_irq;
  logic [7:0]  lvl;
  logic [15:0] d;
  int          bad_count = 0;
  int          checked = 0;

  always #5 i_core_clk = ~i_core_clk;

  adc_analog_model u_ana (.i_level(lvl), .i_pin_sel(o_pin_sel), .o_cmp_hi(cmp_hi));

  adc_sweep_sequencer #(.PINS(8)) u_dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_hi(cmp_hi), .o_pin_sel(o_pin_sel),
    .o_dac_code(dac), .o_busy(o_busy), .o_vref_connect(o_vref_connect), .o_da_oe(o_da_oe),
    .o_irq(o_irq)
  );

  task automatic end_sim();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL reg t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_cyc(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL cycles t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_dac(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL code t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobe for one edge, then idle one edge so strobes never get reassigned in one step.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
    v = o_rdata;
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge i_core_clk);
    cmp_reg({15'h0, o_irq}, {15'h0, e});
  endtask

  task automatic sweep(input int s, input logic r8, input logic cm, input logic md);
    int n;
    int len;
    int lim;
    int pq[$];
    int tq[$];
    logic [2:0] last;
    logic [9:0] w[8];
    logic [15:0] e;
    n = s == 0 ? 2 : s == 1 ? 4 : s == 2 ? 6 : 8;
    len = cm ? 14 : r8 ? 49 : 59;
    lim = md ? 2 * n : n - 1;
    last = 3'h0;
    lvl <= 8'($urandom);
    for (int p = 0; p < 8; p++) begin
      w[p] = 10'($urandom);
      wr(adc_sweep_pkg::ADDR_RESULT0 + 8'(p), {6'h0, w[p]});
    end
    wr(adc_sweep_pkg::ADDR_CTRL1, 16'(s));
    wr(adc_sweep_pkg::ADDR_CMP_SEL, {8'h0, {8{cm}}});
    wr(adc_sweep_pkg::ADDR_CMP_RES, 16'h0000);
    wr(adc_sweep_pkg::ADDR_CTRL0, {9'h0, 1'b1, 4'h0, r8, md});
    for (int t = 0; t < 2000; t++) begin
      @(posedge i_core_clk);
      if (o_busy === 1'b1 && o_pin_sel !== last && pq.size() < lim) begin
        pq.push_back(int'(o_pin_sel));
        tq.push_back(t);
        last = o_pin_sel;
      end
      if (md ? pq.size() == lim : t > 3 && o_busy === 1'b0) begin
        break;
      end
    end
    if (md) begin
      rd(adc_sweep_pkg::ADDR_CTRL0, d);
      cmp_reg(d, {9'h0, 1'b1, 4'h0, r8, md});
      // Only the start bit may change while the converter runs.
      wr(adc_sweep_pkg::ADDR_CTRL0, {14'h0, r8, md});
    end
    repeat (4) @(posedge i_core_clk);
    cmp_cyc(16'(pq.size()), 16'(lim));
    for (int i = 0; i < pq.size(); i++) begin
      cmp_reg(16'(pq[i]), 16'((i + 1) % n));
      if (i > 0 && pq[i] != 0) begin
        cmp_cyc(16'(tq[i] - tq[i - 1]), 16'(len + 2));
      end
    end
    cmp_reg({15'h0, o_busy}, 16'h0000);
    if (!md) begin
      // The ladder keeps the code of the last slot once a single sweep halts.
      e = cm ? {6'h0, w[n - 1][7:0], 2'h2} : {6'h0, {10{lvl[n - 1]}}};
      cmp_dac({6'h0, dac}, e);
    end
    irq_is(!md);
    rd(adc_sweep_pkg::ADDR_CTRL0, d);
    cmp_reg(d, {14'h0, r8, md});
    for (int p = 0; p < 8; p++) begin
      rd(adc_sweep_pkg::ADDR_RESULT0 + 8'(p), d);
      e = {6'h0, w[p]};
      if (!cm && p < (n == 6 ? 5 : n)) begin
        e = lvl[p] ? (r8 ? 16'h00FF : 16'h03FF) : 16'h0000;
      end
      cmp_reg(d, e);
    end
    rd(adc_sweep_pkg::ADDR_CMP_RES, d);
    cmp_reg(d, cm ? {8'h0, lvl} : 16'h0000);
    wr(adc_sweep_pkg::ADDR_IRQ_EN, 16'h0000);
    irq_is(1'b0);
    wr(adc_sweep_pkg::ADDR_IRQ_EN, 16'h0001);
    irq_is(!md);
    wr(adc_sweep_pkg::ADDR_IRQ_CLR, 16'h0001);
    irq_is(1'b0);
    $display("test sel=%0d res8=%0d cmp=%0d repeat=%0d done", s, r8, cm, md);
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    lvl = 8'h00;
    repeat (3) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    @(posedge i_core_clk);
    void'($urandom(32'h5644_1587));
    // The status register is read-only, so this write must leave it clear.
    wr(adc_sweep_pkg::ADDR_IRQ_STAT, 16'h0001);
    for (int i = 0; i < 17; i++) begin
      rd(i < 8 ? 8'(i) : i < 16 ? adc_sweep_pkg::ADDR_RESULT0 + 8'(i - 8) : 8'h20, d);
      cmp_reg(d, 16'h0000);
    end
    $display("test reset values done");
    wr(adc_sweep_pkg::ADDR_DA_CTRL, 16'h0003);
    wr(adc_sweep_pkg::ADDR_CTRL0, 16'h0004);
    @(posedge i_core_clk);
    cmp_reg({13'h0, o_vref_connect, o_da_oe}, 16'h0007);
    wr(adc_sweep_pkg::ADDR_DA_CTRL, 16'h0000);
    wr(adc_sweep_pkg::ADDR_CTRL0, 16'h0000);
    repeat (adc_sweep_pkg::VREF_SETTLE_CYCLES) @(posedge i_core_clk);
    cmp_reg({13'h0, o_vref_connect, o_da_oe}, 16'h0000);
    $display("test output enables done");
    wr(adc_sweep_pkg::ADDR_IRQ_EN, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      sweep(s, s[0], 1'b0, 1'b0);
    end
    sweep(3, 1'b0, 1'b1, 1'b0);
    sweep(2, 1'b1, 1'b0, 1'b1);
    sweep(1, 1'b0, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    #500000;
    bad_count++;
    end_sim();
  end
endmodule // test_adc_sweep_sequencer
